// File: shared/tbm_pkg.sv
// Behaviour
// [R1] Event mode counts pin edges, selectable polarity.
// [R2] Count down; underflow reloads, interrupts, continues.
// [R3] One underflow per n+1 edges.
// [R4] Runs while start flag 1, halts at 0.
// [R5] Event mode read returns live count.
// [R6] Write while halted loads reload and counter.
// [R7] Write while running loads reload only.
// [R8] Written reload enters counter at next underflow.
// [R9] Measure mode clock: div1, 2, 8, 32, sub32.
// [R10] Measure counts up, captures, restarts from zero.
// [R11] Measure mode interrupts at each effective edge.
// [R12] First edge after start raises no interrupt.
// [R13] Overflow interrupts and sets overflow flag.
// [R14] Mode write after next count clears overflow.
// [R15] Measure mode read returns reload contents.
// [R16] Measure read undefined before second edge.
// [R17] Measure mode ignores timer register writes.
// [R18] Period: same-polarity edges; width: all edges.
package tbm_pkg;
  localparam int TBM_W = 16;
  localparam logic [15:0] TBM_CNT_RST = 16'h0000;
  localparam logic [15:0] TBM_RLD_RST = 16'h0000;
  localparam logic [15:0] TBM_CNT_ZERO = 16'h0000;
  localparam logic [15:0] TBM_CNT_MAX = 16'hFFFF;
  localparam logic [4:0] TBM_PRE_RST = 5'h00;

  typedef enum logic [1:0] {
    TBM_MODE_TIMER = 2'b00,
    TBM_MODE_EVENT = 2'b01,
    TBM_MODE_MEASURE = 2'b10,
    TBM_MODE_RSVD = 2'b11
  } tbm_mode_t;

  typedef enum logic [1:0] {
    TBM_EDGE_FALL = 2'b00,
    TBM_EDGE_RISE = 2'b01,
    TBM_EDGE_BOTH = 2'b10,
    TBM_EDGE_RSVD = 2'b11
  } tbm_edge_t;

  typedef enum logic [2:0] {
    TBM_SRC_DIV1 = 3'b000,
    TBM_SRC_DIV2 = 3'b001,
    TBM_SRC_DIV8 = 3'b010,
    TBM_SRC_DIV32 = 3'b011,
    TBM_SRC_SUB32 = 3'b100
  } tbm_src_t;
endpackage

// File: rtl/tbm_prescaler.sv
`timescale 1ns/1ps
module tbm_prescaler
  import tbm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic sub_tick_i,
  input wire logic [2:0] src_sel_i,
  output logic tick_o
);
  logic [4:0] sys_div;
  logic [4:0] sub_div;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sys_div <= TBM_PRE_RST;
    end else begin
      sys_div <= sys_div + 5'h01;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sub_div <= TBM_PRE_RST;
    end else if (sub_tick_i) begin
      sub_div <= sub_div + 5'h01;
    end
  end

  // Each divided tap fires one core cycle when its lower divider bits all read one; div1 ticks every cycle.
  always_comb begin
    unique case (src_sel_i)
      TBM_SRC_DIV1: tick_o = 1'b1; // R9
      TBM_SRC_DIV2: tick_o = sys_div[0];
      TBM_SRC_DIV8: tick_o = &sys_div[2:0];
      TBM_SRC_DIV32: tick_o = &sys_div;
      TBM_SRC_SUB32: tick_o = sub_tick_i & (&sub_div);
      default: tick_o = 1'b0;
    endcase
  end
endmodule

// File: rtl/tbm_channel.sv
`timescale 1ns/1ps
module tbm_channel
  import tbm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic timer_b_input_pin_i,
  input wire logic subclk_tick_i,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic width_meas_i,
  input wire logic [2:0] src_sel_i,
  input wire logic mode_wr_i,
  input wire logic timer_wr_i,
  input wire logic [15:0] timer_wdata_i,
  output logic [15:0] timer_rdata_o,
  output logic overflow_o,
  output logic irq_o
);
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic rise;
  logic fall;
  logic ev_edge;
  logic meas_edge;
  logic is_event;
  logic is_meas;
  logic tick;
  logic [15:0] counter;
  logic [15:0] reload;
  logic seen_edge;
  logic ovf_armed;
  logic meas_edge_pend;

  // The pin is asynchronous to the core clock, so it is synchronised first.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= timer_b_input_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;
  assign is_event = (mode_i == TBM_MODE_EVENT);
  assign is_meas = (mode_i == TBM_MODE_MEASURE);

  always_comb begin
    unique case (edge_sel_i)
      TBM_EDGE_FALL: ev_edge = fall; // R1
      TBM_EDGE_RISE: ev_edge = rise; // R1
      TBM_EDGE_BOTH: ev_edge = rise | fall; // R1
      default: ev_edge = 1'b0;
    endcase
  end

  // Period uses one polarity picked by edge_sel bit 0; width takes every edge.
  assign meas_edge = width_meas_i ? (rise | fall) : (edge_sel_i[0] ? rise : fall); // R18

  tbm_prescaler u_pre (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .sub_tick_i(subclk_tick_i),
    .src_sel_i(src_sel_i),
    .tick_o(tick)
  );

  // A pulse edge is held until the selected count source ticks, so the
  // capture lines up with a count cycle even on slow sources.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meas_edge_pend <= 1'b0;
    end else if (!(start_i && is_meas)) begin
      meas_edge_pend <= 1'b0;
    end else if (tick) begin
      meas_edge_pend <= 1'b0;
    end else if (meas_edge) begin
      meas_edge_pend <= 1'b1;
    end
  end

  logic cap;
  assign cap = start_i && is_meas && tick && (meas_edge || meas_edge_pend);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counter <= TBM_CNT_RST;
    end else if (is_event) begin
      if (timer_wr_i && !start_i) begin
        counter <= timer_wdata_i; // R6
      end else if (start_i && ev_edge) begin // R4
        if (counter == TBM_CNT_ZERO) begin
          counter <= reload; // R2 R3 R8
        end else begin
          counter <= counter - 16'h0001; // R2
        end
      end
    end else if (is_meas && start_i && tick) begin // R4
      if (cap) begin
        counter <= TBM_CNT_ZERO; // R10
      end else begin
        counter <= counter + 16'h0001; // R10
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reload <= TBM_RLD_RST;
    end else if (is_meas) begin
      if (cap) begin
        reload <= counter; // R10 R17
      end
    end else if (timer_wr_i) begin
      reload <= timer_wdata_i; // R6 R7
    end
  end

  // Marks that the first effective edge since start has passed.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_edge <= 1'b0;
    end else if (!start_i) begin
      seen_edge <= 1'b0;
    end else if (cap) begin
      seen_edge <= 1'b1;
    end
  end

  logic ovf_evt;
  assign ovf_evt = is_meas && start_i && tick && !cap && (counter == TBM_CNT_MAX);

  // The overflow flag clears only on a mode write made after one more count
  // cycle; the set takes priority over a clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_o <= 1'b0;
    end else if (ovf_evt) begin
      overflow_o <= 1'b1; // R13
    end else if (mode_wr_i && start_i && ovf_armed) begin
      overflow_o <= 1'b0; // R14
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ovf_armed <= 1'b0;
    end else if (ovf_evt || !overflow_o) begin
      ovf_armed <= 1'b0;
    end else if (start_i && tick) begin
      ovf_armed <= 1'b1; // R14
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (is_event && start_i && ev_edge && !(timer_wr_i && !start_i)
                && counter == TBM_CNT_ZERO) // R2
               || (cap && seen_edge) // R11 R12
               || ovf_evt; // R13
    end
  end

  // Measurement reads show the last result; it is only meaningful once two
  // edges have passed since start.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_rdata_o <= TBM_CNT_RST;
    end else if (is_meas) begin
      timer_rdata_o <= reload; // R15 R16
    end else begin
      timer_rdata_o <= counter; // R5
    end
  end
endmodule

// File: testbench/tbm_pulse_src.sv
`timescale 1ns/1ps
module tbm_pulse_src (
  output logic timer_b_input_pin_o
);
  initial timer_b_input_pin_o = 1'b0;
  // Edges are timed in ns; the half periods tb_top uses are whole core periods, so edges keep a fixed phase of the core clock.
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      #half timer_b_input_pin_o = 1'b1;
      #half timer_b_input_pin_o = 1'b0;
    end
  endtask
endmodule

// File: testbench/tbm_channel_checker.sv
`timescale 1ns/1ps
module tbm_channel_checker
  import tbm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic timer_b_input_pin_i,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [2:0] src_sel_i,
  input wire logic mode_wr_i,
  input wire logic timer_wr_i,
  input wire logic [15:0] timer_wdata_i,
  input wire logic [15:0] timer_rdata_o,
  input wire logic overflow_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_idle_ev;
    (mode_i == 2'h1 && !start_i && !timer_wr_i) [*3];
  endsequence
  // Four quiet cycles cover the pin synchroniser, so no edge is in flight.
  sequence s_quiet_pin;
    (mode_i == 2'h1 && start_i && $stable(timer_b_input_pin_i)) [*4];
  endsequence
  a_halt_no_irq: assert property ((!start_i) [*4] |-> !irq_o) else $error("irq while halted");
  a_halt_hold: assert property (s_idle_ev |=> $stable(timer_rdata_o)) else $error("count moved");
  a_halt_load: assert property (mode_i == 2'h1 && !start_i && timer_wr_i |->
    ##2 timer_rdata_o == $past(timer_wdata_i, 2)) else $error("halted write lost");
  a_run_wr_keep: assert property (s_quiet_pin ##0 timer_wr_i |=> ##1 $stable(timer_rdata_o))
    else $error("running write hit counter");
  a_meas_wr_ign: assert property ((mode_i == 2'h2 && !start_i) [*3] ##0 timer_wr_i |=>
    ##1 $stable(timer_rdata_o)) else $error("measure write taken");
  a_ovf_irq: assert property ($rose(overflow_o) |-> irq_o) else $error("overflow without irq");
  a_ovf_hold: assert property (overflow_o && !mode_wr_i |=> overflow_o) else $error("overflow lost");
  // The previous cycle must have been a running count cycle, or the clear is not yet armed.
  a_ovf_clear: assert property (overflow_o && $past(overflow_o) && $past(start_i) && mode_wr_i && start_i
    && $past(src_sel_i) == 3'h0 |=> !overflow_o) else $error("overflow not cleared");
endmodule
bind tbm_channel tbm_channel_checker u_chk (.*);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 0, rst_b_i = 0, start = 0, mwr = 0, twr = 0, pin, ovf, irq;
  logic [1:0] mode = 2'h0, esel = 2'h0;
  logic [2:0] src = 3'h0;
  logic stk = 0, wm = 0;
  // Captures for a 128-cycle period on div1, div2, div8, div32 and sub32 with a tick every other cycle.
  logic [15:0] exp_src [5] = '{16'h007F, 16'h003F, 16'h000F, 16'h0003, 16'h0001};
  logic [15:0] wd = 16'h0000, rd;
  int mismatches = 0, n_compared = 0, nirq = 0, base;
  initial forever #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (irq === 1'b1) nirq <= nirq + 1;
  always @(posedge core_clk_i) #1 stk = ~stk;
  tbm_pulse_src ps (.timer_b_input_pin_o(pin));
  tbm_channel dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .timer_b_input_pin_i(pin),
    .subclk_tick_i(stk), .start_i(start), .mode_i(mode), .edge_sel_i(esel), .width_meas_i(wm),
    .src_sel_i(src), .mode_wr_i(mwr), .timer_wr_i(twr), .timer_wdata_i(wd),
    .timer_rdata_o(rd), .overflow_o(ovf), .irq_o(irq));
  task automatic tk(int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(logic [15:0] v);
    wd = v;
    twr = 1;
    tk(1);
    twr = 0;
  endtask
  task automatic chk16(logic [15:0] g, logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(logic g, logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #3200000;
    mismatches++;
    wrap_up;
  end
  initial begin
    tk(4);
    rst_b_i = 1;
    tk(2);
    chk16(rd, 16'h0000);
    mode = 2'h1;
    wr(16'h0001);
    tk(2);
    chk16(rd, 16'h0001);
    for (int e = 0; e < 3; e++) begin
      esel = e[1:0];
      start = 1;
      base = nirq;
      ps.pulses(4, 400);
      tk(6);
      start = 0;
      tk(1);
      chk16(16'(nirq - base), (e == 2) ? 16'h0004 : 16'h0002);
      chk16(rd, 16'h0001);
    end
    esel = 2'h1;
    start = 1;
    tk(4);
    wr(16'h0003);
    tk(2);
    chk16(rd, 16'h0001);
    ps.pulses(1, 400);
    tk(6);
    chk16(rd, 16'h0000);
    ps.pulses(1, 400);
    tk(6);
    chk16(rd, 16'h0003);
    start = 0;
    tk(2);
    ps.pulses(2, 400);
    tk(6);
    chk16(rd, 16'h0003);
    mode = 2'h2;
    start = 1;
    base = nirq;
    ps.pulses(3, 400);
    tk(6);
    chk16(16'(nirq - base), 16'h0002);
    chkb(rd >= 16'h0012 && rd <= 16'h0014, 1'b1);
    start = 0;
    tk(2);
    wr(16'h1234);
    tk(2);
    chkb(rd >= 16'h0012 && rd <= 16'h0014, 1'b1);
    for (int s = 0; s < 5; s++) begin
      src = s[2:0];
      start = 1;
      base = nirq;
      ps.pulses(3, 2560);
      tk(70);
      start = 0;
      tk(2);
      chk16(rd, exp_src[s]);
      chk16(16'(nirq - base), 16'h0002);
    end
    src = 3'h0;
    wm = 1;
    start = 1;
    base = nirq;
    ps.pulses(3, 400);
    tk(6);
    start = 0;
    tk(2);
    chk16(rd, 16'h0009);
    chk16(16'(nirq - base), 16'h0005);
    wm = 0;
    start = 1;
    base = nirq;
    tk(65540);
    chkb(ovf, 1'b1);
    chk16(16'(nirq - base), 16'h0001);
    mwr = 1;
    tk(1);
    mwr = 0;
    tk(2);
    chkb(ovf, 1'b0);
    wrap_up;
  end
endmodule
